// [test_copy_mode_sequencer.sv]
/*
  Test and copy mode sequencer with network slot decoding, reached over APB.
  Assumes a motion engine, data store and status sources on the same clock;
  only the direct input pins come from outside and are synchronised.
*/
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "tcm_cfg.svh"
`default_nettype none

module test_copy_mode_sequencer #(
  parameter int unsigned NSLOT = 8,
  parameter bit AC_UNIT = 1'b1,
  parameter int unsigned BLINK_CYC = `TCM_BLINK_MS * `TCM_CLK_KHZ,
  parameter int unsigned HOLD_CYC = `TCM_HOLD_MS * `TCM_CLK_KHZ
) (
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_MOTOR_RUNNING,
  input wire logic I_EDIT_LOCK,
  input wire logic I_INT_BUSY,
  input wire logic I_MOVE_DONE,
  input wire logic I_XFER_DONE,
  input wire logic [2:0] I_XFER_ERR,
  input wire logic I_XFER_MATCH,
  input wire logic I_ALARM,
  input wire logic I_WARN,
  input wire logic I_READY,
  input wire logic I_MOVE,
  input wire logic I_END,
  input wire logic I_AT_HOME,
  input wire logic I_TORQUE_LIMIT,
  input wire logic I_STEP_PHASE,
  input wire logic [2:0] I_ZONE,
  input wire logic [3:0] I_SENSOR,
  input wire logic I_MAIN_SUPPLY,
  input wire logic [7:0] I_DIO_IN,
  input wire logic [7:0] I_DIO_DRIVE,
  output logic [6:0] O_MOTION_CMD,
  output logic [5:0] O_DIRECT_SEL,
  output logic [3:0] O_AUX_CMD,
  output logic O_PRESET_REQ,
  output logic [15:0] O_GENERAL,
  output logic [5:0] O_DATA_SEL,
  output logic [7:0] O_DIN,
  output logic [7:0] O_DIO_OUT,
  output logic [NSLOT-1:0] O_NETWORK_OUTPUT_SLOT,
  output logic O_STEP,
  output logic O_STEP_DIR,
  output logic O_JOG_RUN,
  output logic [15:0] O_SPEED,
  output logic O_MOVE_START,
  output logic O_MOVE_HOME,
  output logic [5:0] O_DATA_NUM,
  output logic O_POS_LOAD,
  output logic [31:0] O_POS_VALUE,
  output logic O_TEACH_STORE,
  output logic O_TEACH_ABS,
  output logic O_XFER_START,
  output logic [1:0] O_XFER_KIND,
  output logic O_ERR_BLINK
);
  import tcm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // slot helpers

  // OR each slot's bit into the vector position named by its code, except TCM_FC_UNUSABLE and codes of 64 and up
  function automatic logic [63:0] decode_in(input logic [63:0] codes,
                                            input logic [7:0] bits);
    logic [63:0] d;
    logic [5:0] c;
    d = 64'h0;
    for (int i = 0; i < 8; i++) begin
      c = codes[i*8 +: 6];
      if (codes[i*8+6 +: 2] == 2'h0 && c != `TCM_FC_UNUSABLE) begin
        d[c] = d[c] | bits[i];
      end
    end
    return d;
  endfunction

  // true when some slot carries the given code
  function automatic logic has_code(input logic [63:0] codes, input logic [5:0] c);
    logic h;
    h = 1'b0;
    for (int i = 0; i < 8; i++) begin
      h = h | (codes[i*8 +: 8] == {2'h0, c});
    end
    return h;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers and synchroniser

  logic pready_r, pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] sel_r, jogspd_r, homespd_r, preset_r;
  logic [7:0] netin_r;
  logic [63:0] incode_r, outcode_r;
  logic set_p_r, esc_p_r;
  logic [1:0] jogkey_r;
  logic [7:0] dio_s1_r, dio_s2_r;
  state_t st_r, st_nxt;
  err_t err_r, err_nxt;
  logic good_r, good_nxt;
  logic move_start_r, move_start_nxt, move_home_r, move_home_nxt;
  logic pos_load_r, pos_load_nxt, teach_r, teach_nxt;
  logic xfer_start_r, xfer_start_nxt;
  logic [1:0] xkind_r, xkind_nxt;
  logic [1:0] key_prev_r;
  logic [31:0] hold_cnt_r, blink_cnt_r;
  logic step_r, step_dir_r, jog_run_r, blink_r;
  logic [15:0] speed_r;
  logic [6:0] motion_r;
  logic [5:0] dsel_r, msel_r;
  logic [3:0] aux_r;
  logic preq_r;
  logic [15:0] gen_r;
  logic [7:0] din_r, dout_r;
  logic [NSLOT-1:0] netout_r;
  logic [127:0] src;
  logic [NSLOT-1:0] netout_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: one wait state, answer registered

  wire acc = I_PSEL & I_PENABLE & ~pready_r;
  wire wr = acc & I_PWRITE;
  wire mapped = (I_PADDR[1:0] == 2'h0) && (I_PADDR <= `TCM_A_NETOUT);
  wire wr_ok = wr & mapped;
  wire [2:0] func = sel_r[`TCM_SEL_FUNC +: 3];
  wire copy_sel = sel_r[`TCM_SEL_COPY];
  wire [5:0] dnum = sel_r[`TCM_SEL_DNUM +: 6];
  wire [63:0] dec = decode_in(incode_r, netin_r);
  wire panel_ok = ~has_code(incode_r, `TCM_FC_PANEL) | dec[`TCM_FC_PANEL];
  wire test_low = st_r inside {ST_IO, ST_JOG, ST_MOVE, ST_PRESET, ST_TEACH};
  wire io_low = (st_r == ST_IO);
  wire [15:0] jog_spd = (jogspd_r[31:16] > jogspd_r[15:0]) ?
                        jogspd_r[31:16] : jogspd_r[15:0];
  wire [31:0] status = {8'h0, dio_s2_r, 4'h0, panel_ok, I_INT_BUSY, blink_r, good_r,
                        err_r, 1'b0, st_r};
  logic [31:0] rd_mux;

  // read mux; unmapped addresses read zero and flag slave error
  always_comb begin
    unique case (I_PADDR)
      `TCM_A_KEY: rd_mux = {28'h0, jogkey_r, 2'h0};
      `TCM_A_SEL: rd_mux = sel_r;
      `TCM_A_JOGSPD: rd_mux = jogspd_r;
      `TCM_A_HOMESPD: rd_mux = homespd_r;
      `TCM_A_PRESET: rd_mux = preset_r;
      `TCM_A_NETIN: rd_mux = {24'h0, netin_r};
      `TCM_A_INCODE0: rd_mux = incode_r[31:0];
      `TCM_A_INCODE1: rd_mux = incode_r[63:32];
      `TCM_A_OUTCODE0: rd_mux = outcode_r[31:0];
      `TCM_A_OUTCODE1: rd_mux = outcode_r[63:32];
      `TCM_A_STATUS: rd_mux = status;
      `TCM_A_NETOUT: rd_mux = {{(32-NSLOT){1'b0}}, netout_r};
      default: rd_mux = 32'h0;
    endcase
  end

  // bus answer and software-written registers
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
      sel_r <= `TCM_SEL_RST;
      jogspd_r <= `TCM_SPD_RST;
      homespd_r <= `TCM_SPD_RST;
      preset_r <= `TCM_SPD_RST;
      netin_r <= 8'h0;
      incode_r <= {`TCM_INCODE_RST, `TCM_INCODE_RST};
      outcode_r <= {`TCM_OUTCODE1_RST, `TCM_OUTCODE0_RST};
      set_p_r <= 1'b0;
      esc_p_r <= 1'b0;
      jogkey_r <= 2'h0;
    end else begin
      pready_r <= acc;
      pslverr_r <= acc & ~mapped;
      prdata_r <= (acc & ~I_PWRITE) ? rd_mux : 32'h0;
      set_p_r <= wr_ok && I_PADDR == `TCM_A_KEY && I_PWDATA[`TCM_KEY_SET];
      esc_p_r <= wr_ok && I_PADDR == `TCM_A_KEY && I_PWDATA[`TCM_KEY_ESC];
      if (wr_ok) begin
        unique case (I_PADDR)
          `TCM_A_KEY: jogkey_r <= I_PWDATA[`TCM_KEY_REV:`TCM_KEY_AHEAD];
          `TCM_A_SEL: sel_r <= I_PWDATA;
          `TCM_A_JOGSPD: jogspd_r <= I_PWDATA;
          `TCM_A_HOMESPD: homespd_r <= I_PWDATA;
          `TCM_A_PRESET: preset_r <= I_PWDATA;
          `TCM_A_NETIN: netin_r <= I_PWDATA[7:0];
          `TCM_A_INCODE0: incode_r[31:0] <= I_PWDATA;
          `TCM_A_INCODE1: incode_r[63:32] <= I_PWDATA;
          `TCM_A_OUTCODE0: outcode_r[31:0] <= I_PWDATA;
          `TCM_A_OUTCODE1: outcode_r[63:32] <= I_PWDATA;
          default: ;
        endcase
      end
    end
  end

  // direct input pins pass two flops before use
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      dio_s1_r <= 8'h0;
      dio_s2_r <= 8'h0;
    end else begin
      dio_s1_r <= I_DIO_IN;
      dio_s2_r <= dio_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sub-function sequencer

  // a confirm at the top checks interlocks before entering a level
  always_comb begin
    st_nxt = st_r;
    err_nxt = err_r;
    good_nxt = good_r;
    move_start_nxt = 1'b0;
    move_home_nxt = move_home_r;
    pos_load_nxt = 1'b0;
    teach_nxt = 1'b0;
    xfer_start_nxt = 1'b0;
    xkind_nxt = xkind_r;
    if (esc_p_r) begin
      err_nxt = E_NONE;
      good_nxt = 1'b0;
    end
    unique case (st_r)
      ST_TOP: begin
        if (set_p_r) begin
          good_nxt = 1'b0;
          err_nxt = E_NONE;
          if (I_INT_BUSY) begin
            err_nxt = E_BUSY;
          end else if (copy_sel) begin
            if (I_EDIT_LOCK) begin
              err_nxt = E_LOCK;
            end else begin
              st_nxt = ST_XFER;
              xfer_start_nxt = 1'b1;
              xkind_nxt = func[1:0];
            end
          end else if (!panel_ok) begin
            err_nxt = E_PANEL;
          end else if (I_MOTOR_RUNNING) begin
            err_nxt = E_OPE;
          end else if ((func == F_PRESET || func == F_TEACH) && I_EDIT_LOCK) begin
            err_nxt = E_LOCK;
          end else begin
            unique case (func)
              F_IO: st_nxt = ST_IO;
              F_JOG: st_nxt = ST_JOG;
              F_DSEL, F_HOME: begin
                st_nxt = ST_MOVE;
                move_start_nxt = 1'b1;
                move_home_nxt = (func == F_HOME);
              end
              F_PRESET: begin
                st_nxt = ST_PRESET;
                pos_load_nxt = 1'b1;
              end
              F_TEACH: st_nxt = ST_TEACH;
              default: ;
            endcase
          end
        end
      end
      ST_IO, ST_JOG: begin
        if (esc_p_r) begin
          st_nxt = ST_TOP;
        end
      end
      ST_TEACH: begin
        if (esc_p_r) begin
          st_nxt = ST_TOP;
        end else if (set_p_r) begin
          if (I_INT_BUSY) begin
            err_nxt = E_BUSY;
          end else begin
            teach_nxt = 1'b1;
          end
        end
      end
      ST_MOVE: begin
        if (I_MOVE_DONE) begin
          st_nxt = ST_TOP;
        end
      end
      ST_PRESET: st_nxt = ST_TOP;
      ST_XFER: begin
        if (I_XFER_DONE) begin
          st_nxt = ST_TOP;
          unique case (I_XFER_ERR)
            3'h0: begin
              if (xkind_r == X_VERIFY) begin
                good_nxt = I_XFER_MATCH;
                err_nxt = I_XFER_MATCH ? E_NONE : E_VERIFY;
              end
            end
            3'h1: err_nxt = E_PROD;
            3'h2: err_nxt = E_HEAD;
            3'h3: err_nxt = E_BCC;
            default: err_nxt = E_EMPTY;
          endcase
        end
      end
      default: st_nxt = ST_TOP;
    endcase
  end

  // one state register keeps a single operation active at a time
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      st_r <= ST_TOP;
      err_r <= E_NONE;
      good_r <= 1'b0;
      move_start_r <= 1'b0;
      move_home_r <= 1'b0;
      pos_load_r <= 1'b0;
      teach_r <= 1'b0;
      xfer_start_r <= 1'b0;
      xkind_r <= X_DOWN;
    end else begin
      st_r <= st_nxt;
      err_r <= err_nxt;
      good_r <= good_nxt;
      move_start_r <= move_start_nxt;
      move_home_r <= move_home_nxt;
      pos_load_r <= pos_load_nxt;
      teach_r <= teach_nxt;
      xfer_start_r <= xfer_start_nxt;
      xkind_r <= xkind_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // jog keys: a press steps once, a press held past HOLD_CYC runs on

  wire jog_mode = (st_r == ST_JOG) || (st_r == ST_TEACH);
  wire [1:0] keys = jog_mode ? jogkey_r : 2'h0;
  wire one_key = ^keys;

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      key_prev_r <= 2'h0;
      hold_cnt_r <= 32'h0;
      step_r <= 1'b0;
      step_dir_r <= 1'b0;
      jog_run_r <= 1'b0;
    end else begin
      key_prev_r <= keys;
      step_r <= one_key && (keys & ~key_prev_r) != 2'h0;
      if (one_key) begin
        step_dir_r <= keys[1];
      end
      hold_cnt_r <= (one_key && hold_cnt_r < HOLD_CYC) ? hold_cnt_r + 32'h1 :
                    (one_key ? hold_cnt_r : 32'h0);
      jog_run_r <= one_key && hold_cnt_r >= HOLD_CYC;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error blink divider: toggles while an error code stands

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      blink_cnt_r <= 32'h0;
      blink_r <= 1'b0;
    end else if (err_r == E_NONE) begin
      blink_cnt_r <= 32'h0;
      blink_r <= 1'b0;
    end else if (blink_cnt_r >= BLINK_CYC - 1) begin
      blink_cnt_r <= 32'h0;
      blink_r <= ~blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output slot sources, indexed by function code

  always_comb begin
    src = 128'h0;
    src[18:1] = dec[18:1];
    src[53:32] = dec[53:32];
    src[63:60] = I_SENSOR;
    src[72:65] = {I_STEP_PHASE, I_TORQUE_LIMIT, I_AT_HOME, I_END, I_MOVE, I_READY, I_WARN,
                  I_ALARM};
    src[75:73] = I_ZONE;
    src[`TCM_FC_BUSY] = I_INT_BUSY;
    src[`TCM_FC_MAINS] = AC_UNIT & I_MAIN_SUPPLY;
    for (int i = 0; i < NSLOT; i++) begin
      netout_nxt[i] = outcode_r[i*8+7] ? 1'b0 : src[outcode_r[i*8 +: 7]];
    end
  end

  // command gating toward the drive; every output leaves from a flop
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      motion_r <= 7'h0;
      dsel_r <= 6'h0;
      aux_r <= 4'h0;
      preq_r <= 1'b0;
      gen_r <= 16'h0;
      msel_r <= 6'h0;
      din_r <= 8'h0;
      dout_r <= 8'h0;
      netout_r <= '0;
      speed_r <= 16'h0;
    end else begin
      motion_r <= test_low ? 7'h0 : dec[7:1];
      dsel_r <= test_low ? 6'h0 : dec[13:8];
      aux_r <= io_low ? 4'h0 : {dec[24], dec[18:16]};
      preq_r <= io_low ? 1'b0 : dec[25];
      gen_r <= io_low ? 16'h0 : dec[47:32];
      msel_r <= io_low ? 6'h0 : dec[53:48];
      din_r <= io_low ? 8'h0 : dio_s2_r;
      dout_r <= io_low ? sel_r[`TCM_SEL_TOG +: 8] : I_DIO_DRIVE;
      netout_r <= netout_nxt;
      // next state, so the speed already stands with the move start pulse
      speed_r <= (st_nxt == ST_MOVE && move_home_nxt) ? homespd_r[15:0] : jog_spd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port drive

  assign O_PRDATA = prdata_r;
  assign O_PREADY = pready_r;
  assign O_PSLVERR = pslverr_r;
  assign O_MOTION_CMD = motion_r;
  assign O_DIRECT_SEL = dsel_r;
  assign O_AUX_CMD = aux_r;
  assign O_PRESET_REQ = preq_r;
  assign O_GENERAL = gen_r;
  assign O_DATA_SEL = msel_r;
  assign O_DIN = din_r;
  assign O_DIO_OUT = dout_r;
  assign O_NETWORK_OUTPUT_SLOT = netout_r;
  assign O_STEP = step_r;
  assign O_STEP_DIR = step_dir_r;
  assign O_JOG_RUN = jog_run_r;
  assign O_SPEED = speed_r;
  assign O_MOVE_START = move_start_r;
  assign O_MOVE_HOME = move_home_r;
  assign O_DATA_NUM = sel_r[`TCM_SEL_DNUM +: 6]; // held register, selects data entry
  assign O_POS_LOAD = pos_load_r;
  assign O_POS_VALUE = preset_r;
  assign O_TEACH_STORE = teach_r;
  assign O_TEACH_ABS = teach_r;
  assign O_XFER_START = xfer_start_r;
  assign O_XFER_KIND = xkind_r;
  assign O_ERR_BLINK = blink_r;

  wire unused_ok = &{1'b0, dnum};
endmodule

`default_nettype wire

// [tcm_cfg.svh]
/*
  Constants of the test/copy mode sequencer: register offsets, field
  positions, reset values, function codes and timing counts.
  Assumes a 100 MHz core clock and APB with 8-bit byte addresses.
*/
`ifndef TCM_CFG_SVH
`define TCM_CFG_SVH

// register byte offsets
`define TCM_A_KEY 8'h00
`define TCM_A_SEL 8'h04
`define TCM_A_JOGSPD 8'h08
`define TCM_A_HOMESPD 8'h0C
`define TCM_A_PRESET 8'h10
`define TCM_A_NETIN 8'h14
`define TCM_A_INCODE0 8'h18
`define TCM_A_INCODE1 8'h1C
`define TCM_A_OUTCODE0 8'h20
`define TCM_A_OUTCODE1 8'h24
`define TCM_A_STATUS 8'h28
`define TCM_A_NETOUT 8'h2C

// field positions
`define TCM_KEY_SET 0
`define TCM_KEY_ESC 1
`define TCM_KEY_AHEAD 2
`define TCM_KEY_REV 3
`define TCM_SEL_FUNC 0
`define TCM_SEL_COPY 3
`define TCM_SEL_DNUM 8
`define TCM_SEL_TOG 16

// reset values
`define TCM_SEL_RST 32'h0000_0000
`define TCM_SPD_RST 32'h0000_0000
`define TCM_INCODE_RST 32'h0000_0000
`define TCM_OUTCODE0_RST 32'h0432_3130
`define TCM_OUTCODE1_RST 32'h4142_4346

// slot function codes with special handling
`define TCM_FC_UNUSABLE 6'h1A
`define TCM_FC_PANEL 6'h1B
`define TCM_FC_BUSY 7'h50
`define TCM_FC_MAINS 7'h52

// timing
`define TCM_CLK_KHZ 100000
`define TCM_BLINK_MS 500
`define TCM_HOLD_MS 300

`endif

// [tcm_pkg.sv]
/*
  Types of the test/copy mode sequencer: states, sub-functions and
  error indications. Constants live in tcm_cfg.svh.
*/
`default_nettype none
package tcm_pkg;
  // one active sub-function at a time
  typedef enum logic [2:0] {ST_TOP, ST_IO, ST_JOG, ST_MOVE, ST_PRESET, ST_TEACH,
                            ST_XFER} state_t;
  // test sub-functions; copy uses codes 0..3 as download, upload, verify, init
  typedef enum logic [2:0] {F_IO, F_JOG, F_DSEL, F_HOME, F_PRESET, F_TEACH} func_t;
  typedef enum logic [1:0] {X_DOWN, X_UP, X_VERIFY, X_INIT} xfer_t;
  typedef enum logic [3:0] {E_NONE, E_OPE, E_PANEL, E_LOCK, E_BUSY, E_PROD, E_HEAD,
                            E_BCC, E_EMPTY, E_VERIFY} err_t;
endpackage
`default_nettype wire

// [tcm_properties.sv]
/*
  Concurrent checks for the test/copy mode sequencer.
  Assumes it is bound to the design and sees only the design's ports.
*/
`timescale 1ns/1ns
`default_nettype none
module tcm_chk #(
  parameter int unsigned NSLOT = 8
) (
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_MOTOR_RUNNING,
  input wire logic I_EDIT_LOCK,
  input wire logic I_ALARM,
  input wire logic I_WARN,
  input wire logic [NSLOT-1:0] O_NETWORK_OUTPUT_SLOT,
  input wire logic [6:0] O_MOTION_CMD,
  input wire logic [5:0] O_DIRECT_SEL,
  input wire logic O_STEP,
  input wire logic O_JOG_RUN,
  input wire logic O_MOVE_START,
  input wire logic O_POS_LOAD,
  input wire logic O_XFER_START,
  input wire logic O_TEACH_STORE
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SYS_RST);
  ////////////////////////////////////////////////////////////////
  // slots 7 and 6 keep their reset codes in the bench, so they echo alarm and warning
  netout_echo_a: assert property (
    !$past(I_SYS_RST) |-> O_NETWORK_OUTPUT_SLOT[7:6] == {$past(I_ALARM), $past(I_WARN)})
    else $error("status slot echo wrong");
  step_single_a: assert property (O_STEP |=> !O_STEP)
    else $error("step pulse too long");
  hold_delay_a: assert property (O_STEP |=> !O_JOG_RUN [*3])
    else $error("continuous jog too early");
  one_operation_a: assert property (
    $onehot0({O_MOVE_START, O_POS_LOAD, O_XFER_START, O_TEACH_STORE}))
    else $error("two operations started together");
  xfer_single_a: assert property (O_XFER_START |=> !O_XFER_START [*4])
    else $error("transfer restarted");
  // in the test levels below the top screen the pendant owns motion, so network motion and direct-select commands are masked; copy transfer leaves them through
  jog_masks_cmd_a: assert property (
    O_JOG_RUN |-> O_MOTION_CMD == 7'h00 && O_DIRECT_SEL == 6'h00)
    else $error("motion input passed during jog");
  move_idle_motor_a: assert property (O_MOVE_START |-> !$past(I_MOTOR_RUNNING))
    else $error("move started while motor running");
  preset_unlocked_a: assert property (O_POS_LOAD |-> !$past(I_EDIT_LOCK))
    else $error("preset under edit lock");
  cover property (O_JOG_RUN);
  cover property (O_POS_LOAD);
  cover property (O_XFER_START);
endmodule
bind test_copy_mode_sequencer tcm_chk #(.NSLOT(NSLOT)) tcm_chk_i (.*);
`default_nettype wire

// [tcm_engine_model.sv]
/*
  Motion and transfer engine model beside the sequencer.
  Assumes start pulses of one cycle; answers after a fixed delay.
*/
`timescale 1ns/1ns
`default_nettype none
module tcm_engine_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic mv_go,
  input wire logic xf_go,
  input wire logic run_frc,
  input wire logic [2:0] err_in,
  input wire logic match_in,
  output logic run,
  output logic mv_done,
  output logic xf_done,
  output logic [2:0] xf_err,
  output logic xf_match
);
  logic [3:0] mv_cnt;
  logic [3:0] xf_cnt;
  logic [2:0] pat;
  ////////////////////////////////////////////////////////////////
  // countdowns end each operation; pat keeps idle result lines moving
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mv_cnt <= 4'h0;
      xf_cnt <= 4'h0;
      mv_done <= 1'b0;
      xf_done <= 1'b0;
      pat <= 3'h0;
    end else begin
      pat <= pat + 3'h1;
      mv_done <= (mv_cnt == 4'h1);
      xf_done <= (xf_cnt == 4'h1);
      mv_cnt <= mv_go ? 4'hA : mv_cnt - {3'h0, mv_cnt != 4'h0};
      xf_cnt <= xf_go ? 4'h6 : xf_cnt - {3'h0, xf_cnt != 4'h0};
    end
  end
  // result codes only mean something with done; otherwise they wander
  assign xf_err = xf_done ? err_in : pat;
  assign xf_match = xf_done ? match_in : pat[0];
  assign run = run_frc | (mv_cnt != 4'h0);
endmodule
`default_nettype wire

// [test_copy_mode_sequencer_tb_top.sv]
/*
  Self-checking bench for the test/copy mode sequencer over APB.
  Assumes the engine model answers moves and transfers.
*/
`timescale 1ns/1ns
`default_nettype none
module test_copy_mode_sequencer_tb_top;
  logic clk = 1'b0, rst = 1'b1, sel = 1'b0, ena = 1'b0, wrt = 1'b0;
  logic frc = 1'b0, lock = 1'b0, bsy = 1'b0, mt = 1'b1, re;
  logic [7:0] pa = 8'h00, din = 8'h00, drv = 8'h00, odin, dout, nout;
  logic [31:0] pw = 32'h0, prd, rq, pv, pl_v, mv_v;
  logic [2:0] xe = 3'h0, xr;
  logic [15:0] sv = 16'h0, gen, spd;
  logic rdy, slv, run, mdn, xdn, xm, stp, sdr, jr, mst, mh, pl, ts, tab, xst, bl, pq;
  logic [6:0] mc;
  logic [5:0] ds, dsl, dn;
  logic [3:0] ax;
  logic [1:0] xk, xk_v;
  int error_cnt = 0, checked = 0, cyc = 0, mvn = 0, pln = 0, stn = 0, xn = 0, tn = 0;
  int ee[5] = '{1, 4, 3, 3, 2};
  test_copy_mode_sequencer #(.BLINK_CYC(8), .HOLD_CYC(5)) test_copy_mode_sequencer_i (
    .I_CORE_CLK(clk), .I_SYS_RST(rst), .I_PSEL(sel), .I_PENABLE(ena), .I_PWRITE(wrt),
    .I_PADDR(pa), .I_PWDATA(pw), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(slv),
    .I_MOTOR_RUNNING(run), .I_EDIT_LOCK(lock), .I_INT_BUSY(bsy), .I_MOVE_DONE(mdn),
    .I_XFER_DONE(xdn), .I_XFER_ERR(xr), .I_XFER_MATCH(xm), .I_ALARM(sv[0]), .I_WARN(sv[1]),
    .I_READY(sv[2]), .I_MOVE(sv[3]), .I_END(sv[4]), .I_AT_HOME(sv[5]), .I_TORQUE_LIMIT(sv[6]),
    .I_STEP_PHASE(sv[7]), .I_ZONE(sv[10:8]), .I_SENSOR(sv[14:11]), .I_MAIN_SUPPLY(sv[15]),
    .I_DIO_IN(din), .I_DIO_DRIVE(drv), .O_MOTION_CMD(mc), .O_DIRECT_SEL(ds), .O_AUX_CMD(ax),
    .O_PRESET_REQ(pq), .O_GENERAL(gen), .O_DATA_SEL(dsl), .O_DIN(odin), .O_DIO_OUT(dout),
    .O_NETWORK_OUTPUT_SLOT(nout), .O_STEP(stp), .O_STEP_DIR(sdr), .O_JOG_RUN(jr), .O_SPEED(spd),
    .O_MOVE_START(mst), .O_MOVE_HOME(mh), .O_DATA_NUM(dn), .O_POS_LOAD(pl),
    .O_POS_VALUE(pv), .O_TEACH_STORE(ts), .O_TEACH_ABS(tab), .O_XFER_START(xst),
    .O_XFER_KIND(xk), .O_ERR_BLINK(bl));
  tcm_engine_model tcm_engine_model_i (.clk(clk), .rst(rst), .mv_go(mst), .xf_go(xst),
    .run_frc(frc), .err_in(xe), .match_in(mt), .run(run), .mv_done(mdn), .xf_done(xdn),
    .xf_err(xr), .xf_match(xm));
  ////////////////////////////////////////////////////////////////
  initial forever #5 clk = ~clk;
  // start pulses last one cycle, so latch them here; also the hang limit
  always @(posedge clk) begin
    cyc++;
    if (mst) begin mvn++; mv_v = {9'h0, mh, dn, spd}; end
    if (pl) begin pln++; pl_v = pv; end
    if (stp) stn++;
    if (ts && tab) tn++;
    if (xst) begin xn++; xk_v = xk; end
    if (cyc == 20000) begin error_cnt++; end_of_test; end
  end
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] x);
    checked++;
    if (s !== x) begin
      error_cnt++;
      $display("unexpected %s exp %0h got %0h", n, x, s);
    end
  endtask
  // one APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    sel <= 1'b1;
    wrt <= w;
    pa <= a;
    pw <= d;
    @(posedge clk);
    ena <= 1'b1;
    // only the bench's cycle limit ends a wait that never sees pready
    do @(posedge clk); while (rdy !== 1'b1);
    rq = prd;
    re = slv;
    sel <= 1'b0;
    ena <= 1'b0;
  endtask
  // select a function, then confirm; also used while the bench holds busy on purpose
  task automatic key(input logic [31:0] s);
    apb(1, 8'h04, s);
    apb(1, 8'h00, 32'h1);
  endtask
  function automatic logic [39:0] dec(int c);
    logic [39:0] r = '0;
    if (c >= 1 && c <= 7) r[32+c] = 1'b1;
    if (c >= 8 && c <= 13) r[19+c] = 1'b1;
    if (c >= 16 && c <= 18) r[7+c] = 1'b1;
    if (c == 24) r[26] = 1'b1;
    if (c == 25) r[22] = 1'b1;
    if (c >= 32 && c <= 47) r[c-26] = 1'b1;
    if (c >= 48 && c <= 53) r[c-48] = 1'b1;
    return r;
  endfunction
  function automatic logic eo(int c);
    if (c >= 65 && c <= 75) return sv[c-65];
    if (c >= 60 && c <= 63) return sv[c-49];
    if (c == 80) return bsy;
    if (c == 82) return sv[15];
    return 1'b0;
  endfunction
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    int c, k, e, t, hs, jm;
    c = $urandom(58);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    apb(0, 8'h20, 0);
    chk("outcode0", rq, 32'h0432_3130);
    apb(0, 8'h30, 0);
    chk("unmapped", {re, rq}, {1'b1, 32'h0});
    apb(1, 8'h14, 1);
    for (c = 0; c < 64; c++) begin
      apb(1, 8'h18, c);
      repeat (2) @(posedge clk);
      chk("in decode", {mc, ds, ax, pq, gen, dsl}, dec(c));
    end
    for (c = 59; c < 83; c++) begin
      {bsy, sv} <= 17'($urandom);
      apb(1, 8'h20, {24'h04_3231, c[7:0]});
      repeat (2) @(posedge clk);
      chk("out decode", nout[0], eo(c));
    end
    {bsy, sv} <= 17'h0;
    $display("test slots done");
    apb(1, 8'h18, 27);
    for (c = 0; c < 5; c++) begin
      frc <= (c == 0);
      bsy <= (c == 1);
      lock <= (c == 2 || c == 3);
      apb(1, 8'h14, c != 4);
      key(c == 2 ? 8 : (c == 3 ? 4 : 1));
      apb(0, 8'h28, 0);
      chk("refusal", {rq[7:4], rq[2:0]}, {ee[c][3:0], 3'h0});
    end
    chk("refused ops", {mvn, pln}, 0);
    frc <= 1'b0;
    bsy <= 1'b0;
    lock <= 1'b0;
    apb(1, 8'h14, 1);
    t = $urandom;
    apb(1, 8'h10, t);
    key(4);
    repeat (4) @(posedge clk);
    chk("preset", {bl, pln, pl_v}, {1'b0, 32'd1, t});
    $display("test refusal and preset done");
    t = $urandom;
    apb(1, 8'h08, t);
    jm = t[31:16] > t[15:0] ? t[31:16] : t[15:0];
    key(1);
    apb(1, 8'h00, 4);
    repeat (12) @(posedge clk);
    chk("jog", {stn, jr, sdr, spd}, {32'd1, 1'b1, 1'b0, jm[15:0]});
    apb(1, 8'h00, 0);
    apb(1, 8'h00, 2);
    t = $urandom;
    apb(1, 8'h0C, t);
    for (c = 3; c > 1; c--) begin
      hs = $urandom % 64;
      key((hs << 8) | c);
      repeat (20) @(posedge clk);
      chk("move", mv_v, {c == 3, hs[5:0], c == 3 ? t[15:0] : jm[15:0]});
    end
    // teach: reverse key held, then confirm stores with absolute mode
    key(5);
    apb(1, 8'h00, 8);
    apb(1, 8'h00, 9);
    repeat (3) @(posedge clk);
    chk("teach", {tn, sdr, spd}, {32'd1, 1'b1, jm[15:0]});
    apb(1, 8'h00, 2);
    $display("test jog and move done");
    for (c = 0; c < 9; c++) begin
      k = c < 4 ? c : (c == 8 ? 2 : 0);
      e = c < 4 ? 0 : (c == 8 ? 9 : c + 1);
      xe <= (c < 4 || c == 8) ? 3'h0 : 3'(c - 3);
      mt <= (c != 8);
      key(8 | k);
      repeat (20) @(posedge clk);
      chk("xfer kind", xk_v, k[1:0]);
      apb(0, 8'h28, 0);
      chk("xfer status", {rq[8], rq[7:4], rq[2:0]}, {c == 2, e[3:0], 3'h0});
    end
    t = bl;
    repeat (8) @(posedge clk);
    chk("blink", bl, !t);
    $display("test copy done");
    din <= 8'($urandom);
    drv <= 8'($urandom);
    t = $urandom;
    key(t & 32'h00FF_0000);
    repeat (4) @(posedge clk);
    chk("io pins", {odin, dout}, {8'h00, t[23:16]});
    apb(0, 8'h28, 0);
    chk("io digits", rq[23:16], din);
    apb(1, 8'h00, 2);
    repeat (3) @(posedge clk);
    chk("io leave", dout, drv);
    $display("test io done");
    end_of_test;
  end
endmodule
`default_nettype wire
